/* File: rtl/lpe_pkg.sv */
// Package holding offsets, field positions and timing constants of the error counters.
`default_nettype none
package lpe_pkg;
  localparam int CNT_W = 16;
  localparam logic [7:0] ADDR_LCV_HI = 8'h42;
  localparam logic [7:0] ADDR_LCV_LO = 8'h43;
  localparam logic [7:0] ADDR_PCV_HI = 8'h44;
  localparam logic [7:0] ADDR_PCV_LO = 8'h45;
  localparam logic [7:0] ADDR_OOS_HI = 8'h46;
  localparam logic [7:0] ADDR_OOS_LO = 8'h47;
  localparam logic [7:0] ADDR_FEB_HI = 8'h48;
  localparam logic [7:0] ADDR_FEB_LO = 8'h49;
  localparam logic [7:0] ADDR_CFG = 8'h41;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_EXCESS_ZEROS = 0;
  localparam int CFG_OOS_SELECT = 1;
  localparam int CFG_FS_REPORT = 2;
  localparam int CFG_E1_CV = 3;
  localparam int CFG_MANUAL_MODE = 4;
  localparam int CFG_FAST_UPDATE = 5;
  localparam int CFG_MANUAL_TRIG = 6;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h7F;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam int T1_FAST_FRAMES = 333;
  localparam int E1_FAST_FRAMES = 500;
  localparam int T1_FRAMES_PER_SEC = 8000;
  localparam int E1_FRAMES_PER_SEC = 8000;
  localparam int FRAME_CNT_W = 13;
endpackage
`default_nettype wire

/* File: rtl/lpe_sync3.sv */
// Three-stage synchroniser for pulse inputs from the line side.
`default_nettype none
module lpe_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;
  logic [WIDTH-1:0] lvl_d;

  // A change is accepted only once stages two and three agree.
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;
  assign rise_out = lvl_d & ~lvl_q;
endmodule
`default_nettype wire

/* File: rtl/lpe_sat_counter.sv */
// Saturating event counter with latch-and-clear into a holding register.
`default_nettype none
module lpe_sat_counter #(
  parameter int WIDTH = lpe_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic count_en,
  input wire logic latch,
  output logic [WIDTH-1:0] held_q
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic [WIDTH-1:0] held_d;

  // Events landing on the latch cycle start the new interval so none is lost.
  always_comb
  begin
    held_d = held_q;
    cnt_d = cnt_q;
    if (latch)
    begin
      held_d = cnt_q;
      cnt_d = count_en ? WIDTH'(1) : '0;
    end
    else if (count_en && (cnt_q != {WIDTH{1'b1}}))
    begin
      cnt_d = cnt_q + WIDTH'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= '0;
      held_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      held_q <= held_d;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/lpe_error_counters.sv */
// Line and path error counters of one T1/E1 receive framer with byte register access.
// Function
// - Line violation count is 16 bits, high byte 42h, low byte 43h.
// - T1 extended superframe: path counter counts CRC6 code word errors.
// - T1 superframe: path counter counts Ft errors, plus Fs when enabled.
// - T1 path counter stops while receive sync is lost.
// - E1 path counter counts CRC4 errors, stops on FAS or CRC4 loss.
// - Path violation count is 16 bits, high byte 44h, low byte 45h.
// - T1 out-of-sync select: count multiframes, only while receive sync is lost.
// - T1 framing select: count Ft or FPS pattern errors, stop during sync loss.
// - E1 out-of-sync counter counts FAS word errors, stops on sync loss.
// - E1 FAS word errors not counted while searching FAS or multiframe sync.
// - Out-of-sync count is 16 bits, high byte 46h, low byte 47h.
// - Far-end block counter works in E1 only, never in T1.
// - Far-end block counter adds one per zero E bit in frames 13, 15.
// - Far-end block counter stops on FAS or CRC4 loss, not CAS loss.
// - Far-end block count is 16 bits, high byte 48h, low byte 49h.
// - Auto update latches each second, or every 333/500 frames when fast.
// - Manual mode: rising trigger bit latches counts next clock and clears counters.
// - Every counter saturates at its maximum and never wraps.
// - Line counter counts BPVs, excess zero runs, or E1 code violations as selected.
`default_nettype none
module lpe_error_counters #(
  parameter int WIDTH = lpe_pkg::CNT_W,
  parameter int FRAMES_PER_SEC = lpe_pkg::T1_FRAMES_PER_SEC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic e1_mode,
  input wire logic t1_esf_mode,
  input wire logic b8zs_enable,
  input wire logic rx_frame_pulse,
  input wire logic rx_multiframe_pulse,
  input wire logic bpv_event,
  input wire logic cv_event,
  input wire logic zero_run_8,
  input wire logic zero_run_16,
  input wire logic crc6_error,
  input wire logic crc4_error,
  input wire logic ft_error,
  input wire logic fs_error,
  input wire logic fps_error,
  input wire logic fas_word_error,
  input wire logic e_bit_zero,
  input wire logic rx_sync_lost,
  input wire logic fas_sync_lost,
  input wire logic crc4_sync_lost,
  input wire logic fas_searching,
  input wire logic mf_searching,
  output logic [7:0] counter_config_reg,
  output logic update_strobe
);
  localparam int NEV = 11;

  logic [NEV-1:0] raw_ev;
  logic [NEV-1:0] ev;
  logic [4:0] st_raw;
  logic [4:0] st;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic trig_prev_q;
  logic trig_prev_d;
  logic [lpe_pkg::FRAME_CNT_W-1:0] frm_q;
  logic [lpe_pkg::FRAME_CNT_W-1:0] frm_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic latch;
  logic manual_latch;
  logic auto_latch;
  logic [lpe_pkg::FRAME_CNT_W-1:0] frm_limit;
  logic lcv_en;
  logic pcv_en;
  logic oos_en;
  logic feb_en;
  logic t1_sync_lost;
  logic e1_sync_lost;
  logic [WIDTH-1:0] lcv_cnt;
  logic [WIDTH-1:0] pcv_cnt;
  logic [WIDTH-1:0] oos_cnt;
  logic [WIDTH-1:0] feb_cnt;

  // Framer pulses come from the line clock and are brought over by pulse edges.
  assign raw_ev = {rx_frame_pulse, rx_multiframe_pulse, bpv_event, cv_event, zero_run_8,
                   zero_run_16, crc6_error, crc4_error, ft_error, fs_error, fps_error};
  assign st_raw = {fas_word_error, e_bit_zero, rx_sync_lost, fas_sync_lost, crc4_sync_lost};

  lpe_sync3 #(
    .WIDTH(NEV)
  ) u_ev_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(raw_ev),
    .level_out(),
    .rise_out(ev)
  );

  lpe_sync3 #(
    .WIDTH(5)
  ) u_st_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(st_raw),
    .level_out(st),
    .rise_out()
  );

  logic fas_err_ev;
  logic ebit_ev;
  logic [1:0] st_edge_q;
  logic [1:0] st_edge_d;
  logic [1:0] srch;

  // Search levels get the same three-stage filter, so no first stage feeds logic.
  lpe_sync3 #(
    .WIDTH(2)
  ) u_srch_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({fas_searching, mf_searching}),
    .level_out(srch),
    .rise_out()
  );

  assign st_edge_d = st[4:3];
  assign fas_err_ev = st[4] & ~st_edge_q[1];
  assign ebit_ev = st[3] & ~st_edge_q[0];

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_edge_q <= 2'h0;
    end
    else
    begin
      st_edge_q <= st_edge_d;
    end
  end

  assign t1_sync_lost = st[2];
  assign e1_sync_lost = st[1] | st[0];

  always_comb
  begin
    if (e1_mode)
    begin
      lcv_en = cfg_q[lpe_pkg::CFG_E1_CV] ? ev[7] : ev[8];
    end
    else
    begin
      lcv_en = ev[8] | (cfg_q[lpe_pkg::CFG_EXCESS_ZEROS] & (b8zs_enable ? ev[6] : ev[5]));
    end
  end

  always_comb
  begin
    if (e1_mode)
    begin
      pcv_en = ev[3] & ~e1_sync_lost;
    end
    else if (t1_esf_mode)
    begin
      pcv_en = ev[4] & ~t1_sync_lost;
    end
    else
    begin
      pcv_en = (ev[2] | (cfg_q[lpe_pkg::CFG_FS_REPORT] & ev[1])) & ~t1_sync_lost;
    end
  end

  always_comb
  begin
    if (e1_mode)
    begin
      oos_en = fas_err_ev & ~t1_sync_lost & ~(|srch);
    end
    else if (cfg_q[lpe_pkg::CFG_OOS_SELECT])
    begin
      oos_en = ev[9] & t1_sync_lost;
    end
    else
    begin
      oos_en = (t1_esf_mode ? ev[0] : ev[2]) & ~t1_sync_lost;
    end
  end

  assign feb_en = e1_mode & ebit_ev & ~e1_sync_lost;

  always_comb
  begin
    if (cfg_q[lpe_pkg::CFG_FAST_UPDATE])
    begin
      frm_limit = e1_mode ? lpe_pkg::FRAME_CNT_W'(lpe_pkg::E1_FAST_FRAMES)
                          : lpe_pkg::FRAME_CNT_W'(lpe_pkg::T1_FAST_FRAMES);
    end
    else
    begin
      frm_limit = lpe_pkg::FRAME_CNT_W'(FRAMES_PER_SEC);
    end
    frm_d = frm_q;
    auto_latch = 1'b0;
    if (ev[10])
    begin
      if (frm_q >= frm_limit - lpe_pkg::FRAME_CNT_W'(1))
      begin
        frm_d = '0;
        auto_latch = ~cfg_q[lpe_pkg::CFG_MANUAL_MODE];
      end
      else
      begin
        frm_d = frm_q + lpe_pkg::FRAME_CNT_W'(1);
      end
    end
  end

  assign trig_prev_d = cfg_q[lpe_pkg::CFG_MANUAL_TRIG];
  assign manual_latch = cfg_q[lpe_pkg::CFG_MANUAL_MODE] & trig_prev_d & ~trig_prev_q;
  assign latch = auto_latch | manual_latch;

  // only the configuration byte accepts writes
  always_comb
  begin
    cfg_d = cfg_q;
    if (reg_wr && (reg_addr == lpe_pkg::ADDR_CFG))
    begin
      cfg_d = reg_wdata & lpe_pkg::CFG_WRITE_MASK;
    end
  end

  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      case (reg_addr)
        lpe_pkg::ADDR_CFG: rdata_d = cfg_q;
        lpe_pkg::ADDR_LCV_HI: rdata_d = lcv_cnt[15:8];
        lpe_pkg::ADDR_LCV_LO: rdata_d = lcv_cnt[7:0];
        lpe_pkg::ADDR_PCV_HI: rdata_d = pcv_cnt[15:8];
        lpe_pkg::ADDR_PCV_LO: rdata_d = pcv_cnt[7:0];
        lpe_pkg::ADDR_OOS_HI: rdata_d = oos_cnt[15:8];
        lpe_pkg::ADDR_OOS_LO: rdata_d = oos_cnt[7:0];
        lpe_pkg::ADDR_FEB_HI: rdata_d = feb_cnt[15:8];
        lpe_pkg::ADDR_FEB_LO: rdata_d = feb_cnt[7:0];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_q <= lpe_pkg::CFG_RESET;
      trig_prev_q <= 1'b0;
      frm_q <= '0;
      rdata_q <= 8'h00;
    end
    else
    begin
      cfg_q <= cfg_d;
      trig_prev_q <= trig_prev_d;
      frm_q <= frm_d;
      rdata_q <= rdata_d;
    end
  end

  lpe_sat_counter #(.WIDTH(WIDTH)) u_lcv (
    .ref_clk(ref_clk), .resetn(resetn), .count_en(lcv_en), .latch(latch), .held_q(lcv_cnt));
  lpe_sat_counter #(.WIDTH(WIDTH)) u_pcv (
    .ref_clk(ref_clk), .resetn(resetn), .count_en(pcv_en), .latch(latch), .held_q(pcv_cnt));
  lpe_sat_counter #(.WIDTH(WIDTH)) u_oos (
    .ref_clk(ref_clk), .resetn(resetn), .count_en(oos_en), .latch(latch), .held_q(oos_cnt));
  lpe_sat_counter #(.WIDTH(WIDTH)) u_feb (
    .ref_clk(ref_clk), .resetn(resetn), .count_en(feb_en), .latch(latch), .held_q(feb_cnt));

  assign reg_rdata = rdata_q;
  assign counter_config_reg = cfg_q;
  assign update_strobe = latch;
endmodule
`default_nettype wire

/* File: sim/lpe_error_counters_properties.sv */
// Checker for register port and update strobe timing of the error counters.
`default_nettype none
module lpe_error_counters_properties #(
  parameter int WIDTH = 16,
  parameter int FRAMES_PER_SEC = 8000
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] counter_config_reg,
  input wire logic update_strobe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_cfg_wr;
    reg_wr && reg_addr == 8'h41;
  endsequence
  sequence s_trig;
    $rose(counter_config_reg[6]) && counter_config_reg[4];
  endsequence
  property p_cfg_load;
    s_cfg_wr |=> counter_config_reg == ($past(reg_wdata) & 8'h7F);
  endproperty
  property p_cfg_keep;
    !(reg_wr && reg_addr == 8'h41) |=> $stable(counter_config_reg);
  endproperty
  property p_trig_strobe;
    s_trig |-> update_strobe;
  endproperty
  // A strobe held two cycles would latch and clear twice, losing counts.
  property p_strobe_one;
    update_strobe |=> !update_strobe;
  endproperty
  property p_manual_only;
    counter_config_reg[4] && !$rose(counter_config_reg[6]) |-> !update_strobe;
  endproperty
  property p_unmapped;
    reg_rd && (reg_addr < 8'h41 || reg_addr > 8'h49) |=> reg_rdata == 8'h00;
  endproperty
  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  property p_bit7;
    s_cfg_wr |-> ##1 !counter_config_reg[7] ##1 !counter_config_reg[7];
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config load wrong");
  a_cfg_keep: assert property (p_cfg_keep) else $error("config changed");
  a_trig_strobe: assert property (p_trig_strobe) else $error("no strobe");
  a_strobe_one: assert property (p_strobe_one) else $error("long strobe");
  a_manual_only: assert property (p_manual_only) else $error("stray strobe");
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  a_bit7: assert property (p_bit7) else $error("config bit 7 set");
endmodule
bind lpe_error_counters lpe_error_counters_properties #(.WIDTH(WIDTH),
  .FRAMES_PER_SEC(FRAMES_PER_SEC)) u_props (.ref_clk(ref_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .counter_config_reg(counter_config_reg),
  .update_strobe(update_strobe));
`default_nettype wire

/* File: sim/lpe_error_counters_tb_top.sv */
// Self-checking bench for the line and path error counters.
`default_nettype none
module lpe_error_counters_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // A short second keeps the automatic update within a brief run.
  localparam int FPS = 20;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] counter_config_reg;
  logic update_strobe;
  logic [2:0] md = 3'h0;
  logic [4:0] lv = 5'h00;
  logic [12:0] ev = 13'h0000;
  logic [7:0] d;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_upd = 0;
  int seed = 32'hA6D47FBF;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (update_strobe === 1'b1)
      n_upd <= n_upd + 1;
  lpe_error_counters #(.FRAMES_PER_SEC(FPS)) uut (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .e1_mode(md[1]), .t1_esf_mode(md[0]), .b8zs_enable(md[2]),
    .rx_frame_pulse(ev[0]), .rx_multiframe_pulse(ev[1]), .bpv_event(ev[2]),
    .cv_event(ev[3]), .zero_run_8(ev[4]), .zero_run_16(ev[5]), .crc6_error(ev[6]),
    .crc4_error(ev[7]), .ft_error(ev[8]), .fs_error(ev[9]), .fps_error(ev[10]),
    .fas_word_error(ev[11]), .e_bit_zero(ev[12]), .rx_sync_lost(lv[0]),
    .fas_sync_lost(lv[1]), .crc4_sync_lost(lv[2]), .fas_searching(lv[3]),
    .mf_searching(lv[4]), .counter_config_reg(counter_config_reg),
    .update_strobe(update_strobe));
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    tick(1);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    tick(1);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic chk16(logic [7:0] a, logic [15:0] e);
    logic [7:0] h;
    rd(a);
    h = d;
    rd(a + 8'h01);
    chk("count", e, {h, d});
  endtask
  // Line events pass a synchroniser, so each level is held three cycles.
  task automatic pulse(int i, int n);
    repeat (n)
    begin
      ev[i] = 1'b1;
      tick(3);
      ev[i] = 1'b0;
      tick(3);
    end
  endtask
  task automatic snap(logic [7:0] c);
    wr(8'h41, c);
    wr(8'h41, c | 8'h40);
    tick(3);
  endtask
  function automatic logic [15:0] exp_cnt(bit k, int n);
    return k ? 16'(n) : 16'h0000;
  endfunction
  // Fast update must latch on the last frame of the interval, not one frame sooner.
  task automatic fast(logic [2:0] m, int f);
    int k;
    int nb;
    nb = 1 + ($unsigned($random(seed)) % 4);
    md = m;
    tick(6);
    wr(8'h41, 8'h20);
    k = n_upd;
    pulse(2, nb);
    pulse(0, f - 1);
    tick(8);
    chk("early", 16'(k), 16'(n_upd));
    pulse(0, 1);
    tick(8);
    chk("fast", 16'(k + 1), 16'(n_upd));
    chk16(8'h42, exp_cnt(1'b1, nb));
  endtask
  task automatic sc(logic [7:0] c, logic [2:0] m, logic [4:0] l, int i, logic [7:0] a,
                    bit k);
    int n;
    n = 1 + ($unsigned($random(seed)) % 4);
    md = m;
    lv = l;
    tick(6);
    snap(c | 8'h10);
    pulse(i, n);
    tick(8);
    snap(c | 8'h10);
    chk16(a, exp_cnt(k, n));
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    tick(2);
    resetn = 1'b1;
    for (int i = 0; i < 8; i++)
      wr(8'h42 + 8'(i), 8'($random(seed)));
    for (int j = 0; j < 4; j++)
      chk16(8'h42 + 8'(2 * j), 16'h0000);
    rd(8'h4A);
    chk("unmapped", 16'h0000, {8'h00, d});
    chk("config", 16'h0000, {8'h00, counter_config_reg});
    pulse(2, 3);
    pulse(0, FPS);
    tick(8);
    chk16(8'h42, 16'h0003);
    chk("updates", 16'h0001, 16'(n_upd));
    sc(8'h00, 3'h0, 5'h00, 2, 8'h42, 1);
    sc(8'h01, 3'h0, 5'h00, 5, 8'h42, 1);
    sc(8'h01, 3'h4, 5'h00, 4, 8'h42, 1);
    sc(8'h08, 3'h2, 5'h01, 3, 8'h42, 1);
    sc(8'h00, 3'h1, 5'h00, 6, 8'h44, 1);
    sc(8'h00, 3'h0, 5'h00, 8, 8'h44, 1);
    sc(8'h00, 3'h0, 5'h00, 9, 8'h44, 0);
    sc(8'h04, 3'h0, 5'h00, 9, 8'h44, 1);
    sc(8'h00, 3'h1, 5'h01, 6, 8'h44, 0);
    sc(8'h00, 3'h2, 5'h00, 7, 8'h44, 1);
    sc(8'h00, 3'h2, 5'h04, 7, 8'h44, 0);
    sc(8'h02, 3'h1, 5'h01, 1, 8'h46, 1);
    sc(8'h00, 3'h1, 5'h00, 10, 8'h46, 1);
    sc(8'h00, 3'h0, 5'h00, 8, 8'h46, 1);
    sc(8'h00, 3'h0, 5'h01, 8, 8'h46, 0);
    sc(8'h00, 3'h2, 5'h00, 11, 8'h46, 1);
    sc(8'h00, 3'h2, 5'h01, 11, 8'h46, 0);
    sc(8'h00, 3'h2, 5'h08, 11, 8'h46, 0);
    sc(8'h00, 3'h2, 5'h10, 11, 8'h46, 0);
    sc(8'h00, 3'h2, 5'h00, 12, 8'h48, 1);
    sc(8'h00, 3'h0, 5'h00, 12, 8'h48, 0);
    sc(8'h00, 3'h2, 5'h02, 12, 8'h48, 0);
    sc(8'h02, 3'h0, 5'h00, 1, 8'h46, 0);
    fast(3'h0, 333);
    fast(3'h2, 500);
    end_sim();
  end
endmodule
`default_nettype wire
